//--- rtl/ums_status_regs.sv
// Modem status, scratch, enhanced mode, divisor and trigger registers over APB.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ums_status_regs (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic resetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ums_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Modem pins, active low: {carrier, ring, DSR, CTS}.
   input wire logic [3:0] modemPinN,
   // Transmit and receive datapath.
   input wire logic txBusy,
   input wire logic rxErrInFifo,
   input wire logic rxErrAtHolding,
   input wire logic [7:0] rxCount,
   input wire logic [7:0] txCount,
   // Events and controls toward the datapath.
   output logic modemIrq,
   output logic lineErrIrq,
   output logic txHalt,
   output logic loopbackEn,
   output logic oversample16,
   output logic trigTableD,
   output logic [5:0] hystChars,
   output logic [15:0] divisorInt,
   output logic [3:0] divisorFrac,
   output logic [7:0] rxTrigLevel,
   output logic [7:0] txTrigLevel
);
   import ums_pkg::*;

   typedef struct packed {
      logic [3:0] delta;
      logic [7:0] modemCtl;
      logic [7:0] scratch;
      logic [7:0] enhMode;
      logic [7:0] divLow;
      logic [7:0] divHigh;
      logic [7:0] divFrac;
      logic [7:0] featCtl;
      logic [7:0] enhFeat;
      logic [7:0] intEn;
      logic [7:0] rxTrig;
      logic [7:0] txTrig;
      logic [31:0] rdata;
      logic ready;
      logic slvErr;
      logic msIrq;
      logic lineIrq;
      logic halt;
      logic ovs16;
      logic tableD;
      logic [5:0] hyst;
      logic [15:0] divInt;
      logic [3:0] divFrc;
   } ums_state_t;

   ums_state_t st_q;
   ums_state_t st_d;

   logic accessPhase;
   logic wrEn;
   logic rdEn;
   logic swap;
   logic enhEn;
   logic hit;
   logic [7:0] rdVal;
   logic [7:0] level;
   logic statusRd;

   ums_modem_if mdm ();

   // Modem inputs are tracked in their own unit; loopback sources are fixed here.
   assign mdm.pinN = modemPinN;
   assign mdm.loop = st_q.modemCtl[MCTL_LOOP_BIT];
   assign mdm.loopSrc = {st_q.modemCtl[3], st_q.modemCtl[2],
                         st_q.modemCtl[0], st_q.modemCtl[1]};

   ums_modem_sync u_modem (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .mdm(mdm)
   );

   // The level is fetched one cycle ahead of the read, so it never lags the selector.
   ums_level_sel u_level (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .rxCount(rxCount),
      .txCount(txCount),
      .mode(st_q.enhMode[1:0]),
      .modeWr(wrEn && paddr == OFF_SCRATCH && swap),
      .levelRd(rdEn && paddr == OFF_SCRATCH && swap),
      .level(level)
   );

   // Bus handshake: one wait state, effects land on the edge that sees pready.
   assign accessPhase = psel & penable & ~st_q.ready;
   assign wrEn = psel & penable & st_q.ready & pwrite;
   assign rdEn = psel & penable & st_q.ready & ~pwrite;
   assign swap = st_q.featCtl[FEAT_SWAP_BIT];
   assign enhEn = st_q.enhFeat[ENH_ENABLE_BIT];
   assign statusRd = rdEn && paddr == OFF_MODEM_STATUS;

   // Every output is a register.
   assign prdata = st_q.rdata;
   assign pready = st_q.ready;
   assign pslverr = st_q.slvErr;
   assign modemIrq = st_q.msIrq;
   assign lineErrIrq = st_q.lineIrq;
   assign txHalt = st_q.halt;
   assign loopbackEn = st_q.modemCtl[MCTL_LOOP_BIT];
   assign oversample16 = st_q.ovs16;
   assign trigTableD = st_q.tableD;
   assign hystChars = st_q.hyst;
   assign divisorInt = st_q.divInt;
   assign divisorFrac = st_q.divFrc;
   assign rxTrigLevel = st_q.rxTrig;
   assign txTrigLevel = st_q.txTrig;

   // Read decode, register writes and derived controls.
   always_comb begin
      st_d = st_q;
      hit = 1'b1;
      rdVal = 8'h00;
      case (paddr)
         OFF_MODEM_STATUS: begin
            rdVal = {mdm.status, st_q.delta};
         end
         OFF_MODEM_CONTROL: begin
            rdVal = st_q.modemCtl;
         end
         OFF_SCRATCH: begin
            rdVal = swap ? level : st_q.scratch;
         end
         OFF_DIV_LOW: begin
            rdVal = st_q.divLow;
         end
         OFF_DIV_HIGH: begin
            rdVal = st_q.divHigh;
         end
         OFF_DIV_FRAC: begin
            rdVal = enhEn ? st_q.divFrac : 8'h00;
         end
         OFF_IDENTITY: begin
            rdVal = st_q.divInt == 16'h0000 ? IDENTITY_CODE : 8'h00;
         end
         OFF_REVISION: begin
            rdVal = st_q.divInt == 16'h0000 ? REVISION_CODE : 8'h00;
         end
         OFF_TRIGGER: begin
            rdVal = 8'h00;
         end
         OFF_FEATURE_CTRL: begin
            rdVal = st_q.featCtl;
         end
         OFF_ENH_FEATURE: begin
            rdVal = st_q.enhFeat;
         end
         OFF_INT_ENABLE: begin
            rdVal = st_q.intEn;
         end
         OFF_INT_STATUS: begin
            rdVal = {5'h00, st_q.halt, st_q.lineIrq, st_q.msIrq};
         end
         default: begin
            hit = 1'b0;
         end
      endcase

      // Answer is captured in the access phase and held with pready.
      st_d.ready = accessPhase;
      st_d.slvErr = accessPhase & ~hit;
      if (accessPhase && !pwrite) begin
         st_d.rdata = {24'h000000, rdVal};
      end

      // Writes take effect on the completing edge only.
      if (wrEn) begin
         case (paddr)
            OFF_MODEM_CONTROL: begin
               if (enhEn) begin
                  st_d.modemCtl = pwdata[7:0];
               end else begin
                  st_d.modemCtl[ENH_LOW_BITS-1:0] = pwdata[ENH_LOW_BITS-1:0];
               end
            end
            OFF_SCRATCH: begin
               if (swap) begin
                  st_d.enhMode = pwdata[7:0];
               end else begin
                  st_d.scratch = pwdata[7:0];
               end
            end
            OFF_DIV_LOW: begin
               st_d.divLow = pwdata[7:0];
            end
            OFF_DIV_HIGH: begin
               st_d.divHigh = pwdata[7:0];
            end
            OFF_DIV_FRAC: begin
               if (enhEn) begin
                  st_d.divFrac = pwdata[7:0];
               end
            end
            OFF_TRIGGER: begin
               if (st_q.featCtl[FEAT_TRIG_TX_BIT]) begin
                  st_d.txTrig = pwdata[7:0];
               end else begin
                  st_d.rxTrig = pwdata[7:0];
               end
            end
            OFF_FEATURE_CTRL: begin
               st_d.featCtl = pwdata[7:0];
            end
            OFF_ENH_FEATURE: begin
               st_d.enhFeat = pwdata[7:0];
            end
            OFF_INT_ENABLE: begin
               if (enhEn) begin
                  st_d.intEn = pwdata[7:0];
               end else begin
                  st_d.intEn[3:0] = pwdata[3:0];
               end
            end
            default: begin
            end
         endcase
      end

      // Only flags actually returned are cleared; a new change wins over the clear.
      if (statusRd) begin
         st_d.delta = st_q.delta & ~st_q.rdata[3:0];
      end
      st_d.delta = st_d.delta | mdm.change;

      // Modem interrupt follows any pending change while enabled.
      st_d.msIrq = st_q.intEn[INT_EN_MODEM_BIT] & (|st_d.delta);

      // Error interrupt at FIFO entry or only once the character is at the head.
      st_d.lineIrq = st_q.enhMode[EMODE_LINE_IMM_BIT] ? rxErrInFifo
                                                      : rxErrAtHolding;

      // CTS deasserted stops the transmitter once the current character is out.
      st_d.halt = st_q.enhFeat[ENH_AUTO_CTS_BIT] & ~mdm.status[0]
                  & (st_q.halt | ~txBusy);

      st_d.ovs16 = st_q.enhMode[EMODE_OVS16_BIT];
      st_d.hyst = HYST_TABLE[{st_q.enhMode[5:4], st_q.featCtl[1:0]}];
      st_d.tableD = st_q.featCtl[5:4] == TABLE_D_CODE;
      st_d.divInt = {st_q.divHigh, st_q.divLow};
      st_d.divFrc = st_q.divFrac[3:0];
   end

   // State register; only reset and scratch writes with swap clear change the scratch.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_q <= '0;
         st_q.scratch <= RST_SCRATCH;
         st_q.enhMode <= RST_ENH_MODE;
         st_q.ovs16 <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence s_status_read;
      statusRd && st_q.rdata[3:0] != 4'h0 && mdm.change == 4'h0;
   endsequence

   sequence s_halt_cause;
      st_q.enhFeat[ENH_AUTO_CTS_BIT] && !mdm.status[0] && !txBusy;
   endsequence

   a_modem_irq_raise: assert property (st_q.intEn[INT_EN_MODEM_BIT] && mdm.change != 4'h0
      |=> modemIrq)
      else $error("Modem change did not raise the interrupt.");
   a_status_clear: assert property (s_status_read |=> (st_q.delta & $past(st_q.rdata[3:0])) == 4'h0)
      else $error("Status read did not clear the returned flags.");
   a_halt_set: assert property (s_halt_cause |=> txHalt ##1 (txHalt || mdm.status[0]))
      else $error("Transmitter not halted by CTS.");
   a_halt_release: assert property (mdm.status[0] |=> !txHalt)
      else $error("Transmitter halt outlived CTS.");
   a_scratch_swap: assert property (wrEn && paddr == OFF_SCRATCH && swap
      |=> $stable(st_q.scratch))
      else $error("Swapped write reached the scratch register.");
   a_frac_locked: assert property (!enhEn |=> $stable(st_q.divFrac))
      else $error("Fraction changed while enhanced bits locked.");
   a_line_imm: assert property (st_q.enhMode[EMODE_LINE_IMM_BIT] && rxErrInFifo |=> lineErrIrq)
      else $error("Immediate error interrupt missing.");
   a_hyst_code: assert property (st_q.enhMode[5:4] == 2'h2 && st_q.featCtl[1:0] == 2'h3
      |=> hystChars == 6'h34)
      else $error("Hysteresis code mapped wrongly.");
   a_trig_route: assert property (wrEn && paddr == OFF_TRIGGER && !st_q.featCtl[FEAT_TRIG_TX_BIT]
      |=> $stable(txTrigLevel) && rxTrigLevel == $past(pwdata[7:0]))
      else $error("Trigger write went to the wrong direction.");
   a_ovs_follow: assert property ($changed(st_q.enhMode[EMODE_OVS16_BIT])
      |=> oversample16 == $past(st_q.enhMode[EMODE_OVS16_BIT]))
      else $error("Oversampling select not applied.");
endmodule : ums_status_regs
`default_nettype wire

//--- rtl/ums_pkg.sv
// Shared constants for the modem status and enhanced register block.
package ums_pkg;
   // APB address width and register byte offsets.
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_MODEM_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_MODEM_CONTROL = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_SCRATCH = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_DIV_LOW = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_DIV_HIGH = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_DIV_FRAC = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_IDENTITY = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_REVISION = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_TRIGGER = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_FEATURE_CTRL = 8'h24;
   localparam logic [ADDR_W-1:0] OFF_ENH_FEATURE = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_INT_ENABLE = 8'h2C;
   localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 8'h30;
   // Reset values.
   localparam logic [7:0] RST_SCRATCH = 8'hFF;
   localparam logic [7:0] RST_ENH_MODE = 8'h80;
   localparam logic [3:0] RST_PIN_IDLE = 4'hF;
   // Identity values; both are arbitrary neutral codes.
   localparam logic [7:0] IDENTITY_CODE = 8'h5C;
   localparam logic [7:0] REVISION_CODE = 8'h03;
   // Field positions.
   localparam int INT_EN_MODEM_BIT = 3;
   localparam int ENH_ENABLE_BIT = 4;
   localparam int ENH_AUTO_CTS_BIT = 7;
   localparam int FEAT_SWAP_BIT = 6;
   localparam int FEAT_TRIG_TX_BIT = 7;
   localparam int MCTL_LOOP_BIT = 4;
   localparam int EMODE_LINE_IMM_BIT = 6;
   localparam int EMODE_OVS16_BIT = 7;
   localparam int ENH_LOW_BITS = 5;
   localparam logic [1:0] LEVEL_ALTERNATE = 2'h3;
   localparam logic [1:0] TABLE_D_CODE = 2'h3;
   // Hysteresis in characters, indexed by the 4-bit selection code.
   localparam logic [5:0] HYST_TABLE [16] = '{6'h00, 6'h04, 6'h06, 6'h08,
      6'h08, 6'h10, 6'h18, 6'h20, 6'h28, 6'h2C, 6'h30, 6'h34,
      6'h0C, 6'h14, 6'h1C, 6'h24};
endpackage : ums_pkg

//--- rtl/ums_modem_if.sv
// Interface between the register file and the modem input tracker.
`timescale 1ns/10ps
`default_nettype none
interface ums_modem_if;
   logic [3:0] pinN;
   logic [3:0] loopSrc;
   logic loop;
   logic [3:0] status;
   logic [3:0] change;
   modport tracker (input pinN, input loopSrc, input loop, output status, output change);
   modport user (output pinN, output loopSrc, output loop, input status, input change);
endinterface : ums_modem_if
`default_nettype wire

//--- rtl/ums_modem_sync.sv
// Modem input synchroniser, loopback mirror and change detector.
`timescale 1ns/10ps
`default_nettype none
module ums_modem_sync (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic resetn,
   // Modem signals.
   ums_modem_if.tracker mdm
);
   import ums_pkg::*;

   typedef struct packed {
      logic [3:0] meta;
      logic [3:0] sync;
      logic [3:0] prev;
   } ums_sync_t;

   ums_sync_t st_q;
   ums_sync_t st_d;

   // Status bits are the complement of the pins, or the control bits in loopback.
   assign mdm.status = mdm.loop ? mdm.loopSrc : ~st_q.sync;

   // Level change on carrier, DSR and CTS; only the trailing edge of ringing.
   genvar i;
   for (i = 0; i < 4; i++) begin : g_change
      if (i == 2) begin : g_ring
         assign mdm.change[i] = st_q.prev[i] & ~mdm.status[i];
      end else begin : g_level
         assign mdm.change[i] = st_q.prev[i] ^ mdm.status[i];
      end
   end

   // Two flops before use; the first flop feeds only the second.
   always_comb begin
      st_d = st_q;
      st_d.meta = mdm.pinN;
      st_d.sync = st_q.meta;
      st_d.prev = mdm.status;
   end

   // Idle pins are high, so reset leaves no spurious change.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_q <= '{meta: RST_PIN_IDLE, sync: RST_PIN_IDLE, prev: 4'h0};
      end else begin
         st_q <= st_d;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_loop_mirror: assert property (mdm.loop |-> mdm.status == mdm.loopSrc)
      else $error("Loopback status does not follow the control bits.");
   a_ring_trailing: assert property (mdm.change[2] |-> $past(mdm.status[2]) && !mdm.status[2])
      else $error("Ring change flagged on the wrong edge.");
endmodule : ums_modem_sync
`default_nettype wire

//--- rtl/ums_level_sel.sv
// FIFO level readback selector with alternating RX and TX counts.
`timescale 1ns/10ps
`default_nettype none
module ums_level_sel (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic resetn,
   // Counts from the FIFOs.
   input wire logic [7:0] rxCount,
   input wire logic [7:0] txCount,
   // Mode and access strobes.
   input wire logic [1:0] mode,
   input wire logic modeWr,
   input wire logic levelRd,
   // Selected level.
   output logic [7:0] level
);
   import ums_pkg::*;

   typedef struct packed {
      logic pickTx;
      logic [7:0] level;
   } ums_level_t;

   ums_level_t st_q;
   ums_level_t st_d;

   assign level = st_q.level;

   // A mode write restarts the alternation at RX; each level read in the alternate mode flips it.
   always_comb begin
      st_d = st_q;
      if (modeWr) begin
         st_d.pickTx = 1'b0;
      end else if (levelRd && mode == LEVEL_ALTERNATE) begin
         st_d.pickTx = ~st_q.pickTx;
      end
      if (!mode[0]) begin
         st_d.level = rxCount;
      end else if (mode[1]) begin
         st_d.level = st_q.pickTx ? txCount : rxCount;
      end else begin
         st_d.level = txCount;
      end
   end

   // State register.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_q <= '{pickTx: 1'b0, level: 8'h00};
      end else begin
         st_q <= st_d;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_alt_first_rx: assert property (modeWr |=> !st_q.pickTx)
      else $error("Alternation does not restart at RX.");
   a_alt_flip: assert property (levelRd && !modeWr && mode == LEVEL_ALTERNATE
      |=> st_q.pickTx != $past(st_q.pickTx))
      else $error("Alternation did not flip after a level read.");
endmodule : ums_level_sel
`default_nettype wire

//--- testbench/ums_far_side.sv
// Model of the modem pins and the transmit and receive datapath levels.
`timescale 1ns/10ps
`default_nettype none
module ums_far_side (
   // Clock.
   input wire logic ref_clk,
   // Modem pins, active low: {carrier, ring, DSR, CTS}.
   output logic [3:0] modemPinN,
   // Datapath levels.
   output logic txBusy,
   output logic rxErrInFifo,
   output logic rxErrAtHolding,
   output logic [7:0] rxCount,
   output logic [7:0] txCount
);
   logic [3:0] pinS;
   logic [3:0] lvlS;
   logic [15:0] cntS;

   // Idle pins are high; outputs move only on a clock edge like real logic.
   initial begin
      pinS = 4'hF;
      lvlS = 4'h0;
      cntS = 16'h0;
      modemPinN = 4'hF;
      {txBusy, rxErrInFifo, rxErrAtHolding} = 3'h0;
      {rxCount, txCount} = 16'h0;
   end

   // Register the commanded levels at each rising edge.
   always @(posedge ref_clk) begin
      modemPinN <= pinS;
      {txBusy, rxErrInFifo, rxErrAtHolding} <= lvlS[2:0];
      {rxCount, txCount} <= cntS;
   end

   // Commands from the bench; non-blocking, so the clocked copy never races the caller.
   task set_pins(input logic [3:0] p);
      pinS <= p;
   endtask : set_pins
   task set_lvl(input logic [3:0] l);
      lvlS <= l;
   endtask : set_lvl
   task set_cnt(input logic [7:0] r, input logic [7:0] t);
      cntS <= {r, t};
   endtask : set_cnt
endmodule : ums_far_side
`default_nettype wire

//--- testbench/tb_ums_status_regs.sv
// Self-checking bench for the modem status and enhanced register block.
`timescale 1ns/10ps
`default_nettype none
module tb_ums_status_regs;
   import ums_pkg::*;
   logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rdQ;
   logic [3:0] modemPinN, divisorFrac;
   logic txBusy, rxErrInFifo, rxErrAtHolding, modemIrq, lineErrIrq, txHalt;
   logic loopbackEn, oversample16, trigTableD, errQ;
   logic [7:0] rxCount, txCount, rxTrigLevel, txTrigLevel;
   logic [5:0] hystChars;
   logic [15:0] divisorInt;
   int error_cnt = 0;
   int n_tests = 0;

   ums_status_regs uut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .modemPinN(modemPinN), .txBusy(txBusy), .rxErrInFifo(rxErrInFifo),
      .rxErrAtHolding(rxErrAtHolding), .rxCount(rxCount), .txCount(txCount),
      .modemIrq(modemIrq), .lineErrIrq(lineErrIrq), .txHalt(txHalt), .loopbackEn(loopbackEn),
      .oversample16(oversample16), .trigTableD(trigTableD), .hystChars(hystChars),
      .divisorInt(divisorInt), .divisorFrac(divisorFrac), .rxTrigLevel(rxTrigLevel),
      .txTrigLevel(txTrigLevel));
   ums_far_side u_far (.ref_clk(ref_clk), .modemPinN(modemPinN), .txBusy(txBusy),
      .rxErrInFifo(rxErrInFifo), .rxErrAtHolding(rxErrAtHolding), .rxCount(rxCount),
      .txCount(txCount));

   // Free-running 100 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Prints the counts and the verdict, then ends the run.
   task final_report;
      $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         error_cnt++;
      end
   endtask : chk

   // One APB transfer; the request holds until pready is seen high at an edge.
   task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk(32'h0, 32'h1);
      end
      rdQ = prdata;
      errQ = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Derived outputs follow the written register one edge later, so wait until they settle.
   task wr8(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
      @(negedge ref_clk);
      @(negedge ref_clk);
   endtask : wr8

   task rd8(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk(rdQ, {24'h0, exp});
   endtask : rd8

   task waitc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : waitc

   // Bounds a hang at well past the expected length of the run.
   initial begin
      waitc(20000);
      error_cnt++;
      final_report();
   end

   // Main sequence.
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      resetn = 1'b0;
      waitc(3);
      resetn <= 1'b1;
      waitc(2);
      // Reset values, then scratch storage.
      rd8(OFF_SCRATCH, 8'hFF);
      chk({31'h0, oversample16}, 32'h1);
      rd8(OFF_MODEM_STATUS, 8'h00);
      wr8(OFF_SCRATCH, 8'h5A);
      rd8(OFF_SCRATCH, 8'h5A);
      // CTS change flags and raises the modem interrupt; a status read clears it.
      wr8(OFF_INT_ENABLE, 8'h08);
      u_far.set_pins(4'hE);
      waitc(6);
      chk({31'h0, modemIrq}, 32'h1);
      rd8(OFF_MODEM_STATUS, 8'h11);
      rd8(OFF_MODEM_STATUS, 8'h10);
      waitc(2);
      chk({31'h0, modemIrq}, 32'h0);
      // Ring start gives no flag; ring end does.
      u_far.set_pins(4'hA);
      waitc(6);
      rd8(OFF_MODEM_STATUS, 8'h50);
      u_far.set_pins(4'hE);
      waitc(6);
      rd8(OFF_MODEM_STATUS, 8'h14);
      // Loopback mirrors the control bits into the status nibble.
      wr8(OFF_MODEM_CONTROL, 8'h1B);
      waitc(4);
      chk({31'h0, loopbackEn}, 32'h1);
      apb(1'b0, OFF_MODEM_STATUS, 8'h00);
      chk(rdQ & 32'hF0, 32'hB0);
      rd8(OFF_MODEM_STATUS, 8'hB0);
      wr8(OFF_MODEM_CONTROL, 8'h14);
      waitc(4);
      apb(1'b0, OFF_MODEM_STATUS, 8'h00);
      chk(rdQ & 32'hF0, 32'h40);
      wr8(OFF_MODEM_CONTROL, 8'h00);
      // Swap: scratch writes set the mode, reads give levels.
      u_far.set_cnt(8'h11, 8'h22);
      wr8(OFF_FEATURE_CTRL, 8'h43);
      wr8(OFF_SCRATCH, 8'h43);
      chk({31'h0, oversample16}, 32'h0);
      rd8(OFF_SCRATCH, 8'h11);
      rd8(OFF_SCRATCH, 8'h22);
      rd8(OFF_SCRATCH, 8'h11);
      // Immediate error interrupt follows the FIFO flag, delayed the holding flag.
      u_far.set_lvl(4'h2);
      waitc(3);
      chk({31'h0, lineErrIrq}, 32'h1);
      wr8(OFF_SCRATCH, 8'h81);
      waitc(2);
      chk({31'h0, lineErrIrq}, 32'h0);
      chk({31'h0, oversample16}, 32'h1);
      rd8(OFF_SCRATCH, 8'h22);
      rd8(OFF_SCRATCH, 8'h22);
      wr8(OFF_SCRATCH, 8'h22);
      rd8(OFF_SCRATCH, 8'h11);
      chk({26'h0, hystChars}, 32'h34);
      u_far.set_lvl(4'h1);
      waitc(3);
      chk({31'h0, lineErrIrq}, 32'h1);
      wr8(OFF_FEATURE_CTRL, 8'h00);
      rd8(OFF_SCRATCH, 8'h5A);
      // Divisor bytes, then the fraction gated by the enhanced enable.
      wr8(OFF_DIV_LOW, 8'h34);
      wr8(OFF_DIV_HIGH, 8'h12);
      wr8(OFF_DIV_FRAC, 8'h07);
      rd8(OFF_DIV_FRAC, 8'h00);
      chk({16'h0, divisorInt}, 32'h1234);
      rd8(OFF_IDENTITY, 8'h00);
      wr8(OFF_ENH_FEATURE, 8'h10);
      wr8(OFF_DIV_FRAC, 8'h07);
      rd8(OFF_DIV_FRAC, 8'h07);
      wr8(OFF_ENH_FEATURE, 8'h00);
      wr8(OFF_DIV_FRAC, 8'h09);
      chk({28'h0, divisorFrac}, 32'h7);
      // Zero divisor exposes identity and revision.
      wr8(OFF_DIV_LOW, 8'h00);
      wr8(OFF_DIV_HIGH, 8'h00);
      rd8(OFF_IDENTITY, IDENTITY_CODE);
      rd8(OFF_REVISION, REVISION_CODE);
      // Trigger levels, TX first, with table D.
      wr8(OFF_FEATURE_CTRL, 8'hB0);
      wr8(OFF_TRIGGER, 8'h20);
      chk({24'h0, txTrigLevel}, 32'h20);
      chk({31'h0, trigTableD}, 32'h1);
      wr8(OFF_FEATURE_CTRL, 8'h30);
      wr8(OFF_TRIGGER, 8'h10);
      chk({24'h0, rxTrigLevel}, 32'h10);
      chk({24'h0, txTrigLevel}, 32'h20);
      rd8(OFF_TRIGGER, 8'h00);
      // Auto CTS: a high CTS pin halts once the character is out, low resumes.
      wr8(OFF_ENH_FEATURE, 8'h90);
      u_far.set_lvl(4'h4);
      u_far.set_pins(4'hF);
      waitc(6);
      chk({31'h0, txHalt}, 32'h0);
      u_far.set_lvl(4'h0);
      waitc(3);
      chk({31'h0, txHalt}, 32'h1);
      u_far.set_pins(4'hE);
      waitc(6);
      chk({31'h0, txHalt}, 32'h0);
      // Unmapped address is refused and reads zero.
      rd8(8'h3C, 8'h00);
      chk({31'h0, errQ}, 32'h1);
      final_report();
   end
endmodule : tb_ums_status_regs
`default_nettype wire
